// ---- verilog/startup_config_regs.v ----
/*
  motor startup configuration register bank: two 32-bit settings
  registers with a simple strobe port, plus decoded settings toward
  the startup and open-loop control logic.
  assumes: single clock, synchronous reset, master never issues read
  and write in the same cycle, reads are answered the following cycle.
*/
`timescale 1ns/10ps
`include "startup_map.vh"

// Function
// RQ1 - bits 20:17 of register one hold align/slow-cycle current cap, 5..95 %.
// RQ2 - bits 16:14 select probe clock rate, 50 Hz up to 10000 Hz.
// RQ3 - bits 13:9 set probe current threshold; codes above Fh invalid.
// RQ4 - bits 7:6 select advance angle 0, 30, 60, 90 degrees.
// RQ5 - bits 5:4 give probe run count, one to four averaged.
// RQ6 - bit 3 picks dedicated open-loop cap or general cap.
// RQ7 - bit 2 enables quadrature current ramp-down at loop handoff.
// RQ8 - bit 1 enables active braking during deceleration.
// RQ9 - bit 0 selects forward or reverse open-loop parameter set.
// RQ10 - register two sits at 86h and resets to zero.
// RQ11 - bits 30:27 of register two hold open-loop current cap.
// RQ12 - bits 26:23 hold linear acceleration code; Ah undocumented.
// RQ13 - bits 22:19 hold square acceleration code, 0 to 10000.
// RQ14 - bit 18 enables automatic open-to-closed loop handoff.
// RQ15 - register one sits at 84h and resets to zero.
// RQ16 - bits 30:29 of register one select startup method.
// RQ17 - every bit reads back as written, zero until written.

module startup_config_regs (
  input  wire        clk,
  input  wire        rst,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rdata,
  output reg         rd_err,
  // general cap and reverse-drive set from neighbouring registers
  input  wire [3:0]  general_current_cap,
  input  wire [3:0]  reverse_ol_cap_code,
  input  wire [3:0]  reverse_accel_linear_coeff,
  input  wire [3:0]  reverse_accel_square_coeff,
  // decoded settings to the control core
  output wire [1:0]  startup_method_select,
  output wire        initial_position_detection,
  output wire [9:0]  align_slow_cycle_current_cap,
  output wire [13:0] position_probe_clock_rate,
  output wire [9:0]  position_probe_current_threshold,
  output wire        probe_threshold_valid,
  output wire [6:0]  position_probe_advance_angle,
  output wire [2:0]  position_probe_repeat_count,
  output wire        open_loop_limit_source_select,
  output reg  [3:0]  open_loop_current_cap,
  output wire [9:0]  open_loop_cap_permille,
  output wire        quadrature_current_rampdown_enable,
  output wire        active_brake_enable,
  output wire        reverse_drive_param_select,
  output reg  [3:0]  open_loop_accel_linear_coeff,
  output reg  [3:0]  open_loop_accel_square_coeff,
  output wire        accel_linear_undefined,
  output wire        auto_handoff_enable
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [31:0] settings_one_r;
  reg  [31:0] settings_two_r;
  reg  [3:0]  cap_sel_code;
  wire        hit_one;
  wire        hit_two;

  // address decode, exact offsets only
  assign hit_one = (addr == `STARTUP_ONE_OFFSET);  // RQ15
  assign hit_two = (addr == `STARTUP_TWO_OFFSET);  // RQ10

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------

  // whole word stored, reserved bits included so they read back
  always @(posedge clk) begin
    if (rst) begin
      settings_one_r <= `STARTUP_ONE_RESET;  // RQ15
      settings_two_r <= `STARTUP_TWO_RESET;  // RQ10
    end else if (wr_en) begin
      if (hit_one) begin
        settings_one_r <= wdata;  // RQ17
      end
      if (hit_two) begin
        settings_two_r <= wdata;  // RQ17
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------

  // data valid only in the cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (rst) begin
      rdata  <= 32'h00000000;
      rd_err <= 1'b0;
    end else if (rd_en) begin
      rd_err <= ~(hit_one | hit_two);
      if (hit_one) begin
        rdata <= settings_one_r;  // RQ17
      end else if (hit_two) begin
        rdata <= settings_two_r;  // RQ17
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata  <= 32'h00000000;
      rd_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // direct control bits
  // ----------------------------------------------------------------
  assign startup_method_select =
    settings_one_r[`METHOD_HI:`METHOD_LO];  // RQ16
  assign initial_position_detection =
    (startup_method_select == `METHOD_PROBE);  // RQ16
  assign open_loop_limit_source_select =
    settings_one_r[`LIMIT_SRC_BIT];  // RQ6
  assign quadrature_current_rampdown_enable =
    settings_one_r[`RAMPDOWN_BIT];  // RQ7
  assign active_brake_enable =
    settings_one_r[`BRAKE_BIT];  // RQ8
  assign reverse_drive_param_select =
    settings_one_r[`REVERSE_SEL_BIT];  // RQ9
  assign auto_handoff_enable =
    settings_two_r[`HANDOFF_AUTO_BIT];  // RQ14

  // ----------------------------------------------------------------
  // open-loop parameter selection
  // ----------------------------------------------------------------

  // reverse set replaces current and both coefficients together
  always @* begin
    if (reverse_drive_param_select) begin  // RQ9
      cap_sel_code                 = reverse_ol_cap_code;
      open_loop_accel_linear_coeff = reverse_accel_linear_coeff;
      open_loop_accel_square_coeff = reverse_accel_square_coeff;
    end else begin
      cap_sel_code                 = settings_two_r[`OL_CAP_HI:`OL_CAP_LO];  // RQ11
      open_loop_accel_linear_coeff = settings_two_r[`ACC_LIN_HI:`ACC_LIN_LO];  // RQ12
      open_loop_accel_square_coeff = settings_two_r[`ACC_SQ_HI:`ACC_SQ_LO];  // RQ13
    end
  end

  // general cap wins over the dedicated one when the source bit is set
  always @* begin
    if (open_loop_limit_source_select) begin  // RQ6
      open_loop_current_cap = general_current_cap;
    end else begin
      open_loop_current_cap = cap_sel_code;
    end
  end

  // code Ah of the linear table has no value; flag it for the core
  assign accel_linear_undefined =
    (open_loop_accel_linear_coeff == `ACC_LIN_UNDEFINED);  // RQ12

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  startup_field_decode u_decode (
    .align_cap_code     (settings_one_r[`ALIGN_CAP_HI:`ALIGN_CAP_LO]),
    .ol_cap_code        (open_loop_current_cap),
    .probe_clk_code     (settings_one_r[`PROBE_CLK_HI:`PROBE_CLK_LO]),
    .probe_thr_code     (settings_one_r[`PROBE_THR_HI:`PROBE_THR_LO]),
    .probe_angle_code   (settings_one_r[`PROBE_ANGLE_HI:`PROBE_ANGLE_LO]),
    .probe_repeat_code  (settings_one_r[`PROBE_REPEAT_HI:`PROBE_REPEAT_LO]),
    .align_cap_permille (align_slow_cycle_current_cap),
    .ol_cap_permille    (open_loop_cap_permille),
    .probe_clk_hz       (position_probe_clock_rate),
    .probe_thr_permille (position_probe_current_threshold),
    .probe_thr_valid    (probe_threshold_valid),
    .probe_angle_deg    (position_probe_advance_angle),
    .probe_runs         (position_probe_repeat_count)
  );

endmodule

// ---- verilog/startup_map.vh ----
/*
  startup register map: offsets, field positions, reset values and
  decode constants for the two motor startup settings registers.
  assumes: included by the register bank and its field decoder only.
*/
`ifndef STARTUP_MAP_VH
`define STARTUP_MAP_VH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define STARTUP_ONE_OFFSET      8'h84
`define STARTUP_TWO_OFFSET      8'h86
`define STARTUP_ONE_RESET       32'h00000000
`define STARTUP_TWO_RESET       32'h00000000

// ----------------------------------------------------------------
// startup_settings_one field positions
// ----------------------------------------------------------------
`define METHOD_HI               30
`define METHOD_LO               29
`define ALIGN_CAP_HI            20
`define ALIGN_CAP_LO            17
`define PROBE_CLK_HI            16
`define PROBE_CLK_LO            14
`define PROBE_THR_HI            13
`define PROBE_THR_LO            9
`define RESERVED_ONE_BIT        8
`define PROBE_ANGLE_HI          7
`define PROBE_ANGLE_LO          6
`define PROBE_REPEAT_HI         5
`define PROBE_REPEAT_LO         4
`define LIMIT_SRC_BIT           3
`define RAMPDOWN_BIT            2
`define BRAKE_BIT               1
`define REVERSE_SEL_BIT         0

// ----------------------------------------------------------------
// startup_settings_two field positions
// ----------------------------------------------------------------
`define OL_CAP_HI               30
`define OL_CAP_LO               27
`define ACC_LIN_HI              26
`define ACC_LIN_LO              23
`define ACC_SQ_HI               22
`define ACC_SQ_LO               19
`define HANDOFF_AUTO_BIT        18

// ----------------------------------------------------------------
// decode constants
// ----------------------------------------------------------------
`define METHOD_PROBE            2'h2
`define PROBE_THR_LAST_VALID    5'h0F
`define ACC_LIN_UNDEFINED       4'hA
`define ANGLE_STEP_DEG          7'h1E

`endif

// ---- verilog/startup_field_decode.v ----
/*
  field decoder: turns the raw startup codes into engineering values
  (tenths of a percent, hertz, degrees, run count) for the control core.
  assumes: codes come from the register bank flip-flops, except the open-loop cap code, picked by the source and reverse selects.
*/
`timescale 1ns/10ps
`include "startup_map.vh"

module startup_field_decode (
  input  wire [3:0]  align_cap_code,
  input  wire [3:0]  ol_cap_code,
  input  wire [2:0]  probe_clk_code,
  input  wire [4:0]  probe_thr_code,
  input  wire [1:0]  probe_angle_code,
  input  wire [1:0]  probe_repeat_code,
  output wire [9:0]  align_cap_permille,
  output wire [9:0]  ol_cap_permille,
  output reg  [13:0] probe_clk_hz,
  output reg  [9:0]  probe_thr_permille,
  output wire        probe_thr_valid,
  output wire [6:0]  probe_angle_deg,
  output wire [2:0]  probe_runs
);

  // percent table shared by both current caps, so it is a function
  function [9:0] cap_permille;
    input [3:0] code;
    begin
      case (code)
        4'h0: cap_permille = 10'h032;  // 5 %
        4'h1: cap_permille = 10'h064;
        4'h2: cap_permille = 10'h096;
        4'h3: cap_permille = 10'h0C8;
        4'h4: cap_permille = 10'h0FA;
        4'h5: cap_permille = 10'h12C;
        4'h6: cap_permille = 10'h190;  // 40 %
        4'h7: cap_permille = 10'h1F4;
        4'h8: cap_permille = 10'h258;
        4'h9: cap_permille = 10'h28A;  // 65 %
        4'hA: cap_permille = 10'h2BC;
        4'hB: cap_permille = 10'h2EE;
        4'hC: cap_permille = 10'h320;
        4'hD: cap_permille = 10'h352;
        4'hE: cap_permille = 10'h384;
        default: cap_permille = 10'h3B6;  // 95 %
      endcase
    end
  endfunction

  assign align_cap_permille = cap_permille(align_cap_code);  // RQ1
  assign ol_cap_permille    = cap_permille(ol_cap_code);     // RQ11

  // probe clock rate table
  always @* begin
    case (probe_clk_code)  // RQ2
      3'h0: probe_clk_hz = 14'h0032;
      3'h1: probe_clk_hz = 14'h0064;
      3'h2: probe_clk_hz = 14'h00FA;
      3'h3: probe_clk_hz = 14'h01F4;
      3'h4: probe_clk_hz = 14'h03E8;
      3'h5: probe_clk_hz = 14'h07D0;
      3'h6: probe_clk_hz = 14'h1388;
      default: probe_clk_hz = 14'h2710;
    endcase
  end

  // probe threshold; upper half codes have no meaning, flagged invalid
  always @* begin
    case (probe_thr_code)  // RQ3
      5'h00: probe_thr_permille = 10'h019;
      5'h01: probe_thr_permille = 10'h032;
      5'h02: probe_thr_permille = 10'h04B;
      5'h03: probe_thr_permille = 10'h064;
      5'h04: probe_thr_permille = 10'h07D;
      5'h05: probe_thr_permille = 10'h096;
      5'h06: probe_thr_permille = 10'h0C8;
      5'h07: probe_thr_permille = 10'h0FA;
      5'h08: probe_thr_permille = 10'h12C;
      5'h09: probe_thr_permille = 10'h16F;  // 36.67 % rounded
      5'h0A: probe_thr_permille = 10'h190;
      5'h0B: probe_thr_permille = 10'h1D3;
      5'h0C: probe_thr_permille = 10'h215;
      5'h0D: probe_thr_permille = 10'h258;
      5'h0E: probe_thr_permille = 10'h29B;
      5'h0F: probe_thr_permille = 10'h2D0;  // 72 %
      default: probe_thr_permille = 10'h000;
    endcase
  end

  assign probe_thr_valid = (probe_thr_code <= `PROBE_THR_LAST_VALID);  // RQ3

  // 30 degree steps, repeat code plus one runs
  assign probe_angle_deg = `ANGLE_STEP_DEG * {5'h00, probe_angle_code};  // RQ4
  assign probe_runs      = {1'b0, probe_repeat_code} + 3'h1;             // RQ5

endmodule

// ---- verification/startup_config_regs_sva.sv ----
/*
  checker for the startup settings register bank: read timing, refusal
  of unmapped reads, read-back and field mapping of written words.
  assumes: bound to startup_config_regs, single clock, sync reset.
*/
`timescale 1ns/10ps
module startup_config_regs_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic        rd_err,
  input wire logic [3:0]  general_current_cap,
  input wire logic [1:0]  startup_method_select,
  input wire logic        initial_position_detection,
  input wire logic [6:0]  position_probe_advance_angle,
  input wire logic [2:0]  position_probe_repeat_count,
  input wire logic        open_loop_limit_source_select,
  input wire logic [3:0]  open_loop_current_cap,
  input wire logic        active_brake_enable,
  input wire logic        auto_handoff_enable
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire w1 = wr_en && addr == 8'h84;
  wire w2 = wr_en && addr == 8'h86;
  // read port answers only in the cycle after a strobe
  a_idle_rdata_zero: assert property (!$past(rd_en) |-> rdata == 32'h0 && !rd_err)
    else $error("rdata or rd_err set without a read");
  a_unmapped_read_err: assert property (rd_en && addr != 8'h84 && addr != 8'h86 |=> rd_err && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_read_ok: assert property (rd_en && (addr == 8'h84 || addr == 8'h86) |=> !rd_err)
    else $error("mapped read flagged");
  a_readback_one: assert property (w1 ##1 rd_en && addr == 8'h84 |=> rdata == $past(wdata, 2))
    else $error("register one read-back differs");
  a_readback_two: assert property (w2 ##1 rd_en && addr == 8'h86 |=> rdata == $past(wdata, 2))
    else $error("register two read-back differs");
  a_method_probe_flag: assert property (w1 |=> startup_method_select == $past(wdata[30:29]) &&
    initial_position_detection == ($past(wdata[30:29]) == 2'h2))
    else $error("startup method decode wrong");
  a_angle_and_runs: assert property (w1 |=>
    position_probe_advance_angle == 7'h1E * $past(wdata[7:6])
    && position_probe_repeat_count == $past(wdata[5:4]) + 3'h1)
    else $error("angle or run count decode wrong");
  a_brake_bit: assert property (w1 |=> active_brake_enable == $past(wdata[1]))
    else $error("brake enable wrong");
  a_handoff_bit: assert property (w2 |=> auto_handoff_enable == $past(wdata[18]))
    else $error("handoff enable wrong");
  a_general_cap_sel: assert property (open_loop_limit_source_select |-> open_loop_current_cap == general_current_cap)
    else $error("general cap not selected");
  c_write_read: cover property (w1 ##1 rd_en);
  c_unmapped: cover property (rd_err);
  c_probe_start: cover property (initial_position_detection);
endmodule
bind startup_config_regs startup_config_regs_sva u_startup_config_regs_sva (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rd_err(rd_err),
  .general_current_cap(general_current_cap), .startup_method_select(startup_method_select),
  .initial_position_detection(initial_position_detection),
  .position_probe_advance_angle(position_probe_advance_angle),
  .position_probe_repeat_count(position_probe_repeat_count),
  .open_loop_limit_source_select(open_loop_limit_source_select),
  .open_loop_current_cap(open_loop_current_cap), .active_brake_enable(active_brake_enable),
  .auto_handoff_enable(auto_handoff_enable));

// ---- verification/testbench.sv ----
/*
  testbench for the startup settings register bank: every field code,
  random words with back-to-back read-back, unmapped access, reset.
  assumes: design files on the include path, 25 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
  reg         clk, rst, wr_en, rd_en;
  reg  [7:0]  addr;
  reg  [31:0] wdata, r1, r2, rnd;
  reg  [3:0]  gcap, rcap, rlin, rsq, oc, lc;
  wire [31:0] rdata;
  wire [1:0]  meth;
  wire [9:0]  acap, tpm, olpm;
  wire [13:0] hz;
  wire [6:0]  ang;
  wire [2:0]  runs;
  wire [3:0]  olc, lin, sq;
  wire        rd_err, probe_sel, tval, src, ramp, brk, rev, undef, hand;
  integer     error_cnt, n_checks, seed, i;
  startup_config_regs u_startup_config_regs (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rd_err(rd_err), .general_current_cap(gcap),
    .reverse_ol_cap_code(rcap), .reverse_accel_linear_coeff(rlin),
    .reverse_accel_square_coeff(rsq), .startup_method_select(meth),
    .initial_position_detection(probe_sel), .align_slow_cycle_current_cap(acap),
    .position_probe_clock_rate(hz), .position_probe_current_threshold(tpm),
    .probe_threshold_valid(tval), .position_probe_advance_angle(ang),
    .position_probe_repeat_count(runs), .open_loop_limit_source_select(src),
    .open_loop_current_cap(olc), .open_loop_cap_permille(olpm),
    .quadrature_current_rampdown_enable(ramp), .active_brake_enable(brk),
    .reverse_drive_param_select(rev), .open_loop_accel_linear_coeff(lin),
    .open_loop_accel_square_coeff(sq), .accel_linear_undefined(undef),
    .auto_handoff_enable(hand));
  // ----------------------------------------
  // expectation tables, permille and hertz
  // ----------------------------------------
  function [13:0] cap_pm(input [3:0] c);
    reg [159:0] t;
    begin
      t = {10'd950, 10'd900, 10'd850, 10'd800, 10'd750, 10'd700, 10'd650, 10'd600,
           10'd500, 10'd400, 10'd300, 10'd250, 10'd200, 10'd150, 10'd100, 10'd50};
      cap_pm = t[c*10 +: 10];
    end
  endfunction
  function [13:0] hz_of(input [2:0] c);
    reg [111:0] t;
    begin
      t = {14'd10000, 14'd5000, 14'd2000, 14'd1000, 14'd500, 14'd250, 14'd100, 14'd50};
      hz_of = t[c*14 +: 14];
    end
  endfunction
  function [13:0] thr_pm(input [4:0] c);
    reg [159:0] t;
    begin
      t = {10'd720, 10'd667, 10'd600, 10'd533, 10'd467, 10'd400, 10'd367, 10'd300,
           10'd250, 10'd200, 10'd150, 10'd125, 10'd100, 10'd75, 10'd50, 10'd25};
      thr_pm = c[4] ? 14'h0000 : t[c[3:0]*10 +: 10];
    end
  endfunction
  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task chk_word(input [47:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk_dec(input [47:0] nm, input [13:0] e, input [13:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s expected %0d seen %0d", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e, input ee);
    begin
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk_word("rdata", e, rdata);
      chk_dec("rderr", {13'h0, ee}, {13'h0, rd_err});
    end
  endtask
  task idle;
    begin
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      #1;
    end
  endtask
  task chk_all;
    begin
      oc = r1[3] ? gcap : (r1[0] ? rcap : r2[30:27]);
      lc = r1[0] ? rlin : r2[26:23];
      chk_dec("meth", {12'h0, r1[30:29]}, {12'h0, meth});
      chk_dec("probe", {13'h0, r1[30:29] == 2'h2}, {13'h0, probe_sel});
      chk_dec("acap", cap_pm(r1[20:17]), {4'h0, acap});
      chk_dec("clk", hz_of(r1[16:14]), hz);
      chk_dec("thr", thr_pm(r1[13:9]), {4'h0, tpm});
      chk_dec("tval", {13'h0, r1[13:9] <= 5'h0F}, {13'h0, tval});
      chk_dec("angle", 14'h001E * r1[7:6], {7'h00, ang});
      chk_dec("runs", {12'h0, r1[5:4]} + 14'h0001, {11'h0, runs});
      chk_dec("flags", {10'h0, r1[3:0]}, {10'h0, src, ramp, brk, rev});
      chk_dec("olcap", {10'h0, oc}, {10'h0, olc});
      chk_dec("olpm", cap_pm(oc), {4'h0, olpm});
      chk_dec("lin", {10'h0, lc}, {10'h0, lin});
      chk_dec("undef", {13'h0, lc == 4'hA}, {13'h0, undef});
      chk_dec("sq", {10'h0, r1[0] ? rsq : r2[22:19]}, {10'h0, sq});
      chk_dec("hand", {13'h0, r2[18]}, {13'h0, hand});
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // 20000 cycles is ample for a run of some 650; a hang counts as a failure
  initial begin
    #800000;
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    {seed, error_cnt, n_checks, r1, r2} = {32'd40904, 64'h0, 64'h0};
    {rst, wr_en, rd_en, addr, wdata, gcap, rcap, rlin, rsq} = {1'b1, 58'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 72; i = i + 1) begin
      if (i == 0 || i == 71) begin
        idle;
        chk_all;
        rd(8'h84, 32'h0, 1'b0);
        rd(8'h86, 32'h0, 1'b0);
      end
      @(posedge clk);
      rnd = $random(seed);
      {gcap, rcap, rlin, rsq} <= rnd[15:0];
      // first 32 passes walk every code of each field, the rest are random
      r1 = {1'b0, i[1:0], 8'h00, i[3:0], i[2:0], i[4:0], 1'b0, i[1:0], i[1:0], i[3:0]};
      r2 = {1'b1, i[3:0], i[3:0], ~i[3:0], i[0], 18'h3FFFF};
      if (i > 31) {r1, r2} = {$random(seed), $random(seed)};
      wr(8'h84, r1);
      rd(8'h84, r1, 1'b0);
      wr(8'h86, r2);
      rd(8'h86, r2, 1'b0);
      idle;
      chk_all;
      // unmapped neighbour 88h is refused and leaves both registers alone
      if (i % 8 == 3) begin
        wr(8'h85 + i[1:0], 32'hFFFFFFFF);
        rd(8'h85 + i[1:0], 32'h0, 1'b1);
        rd(8'h84, r1, 1'b0);
        rd(8'h86, r2, 1'b0);
      end
      if (i == 70) begin
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        {r1, r2} = 64'h0;
      end
    end
    final_report;
  end
endmodule
